/* File: ocfr_ctrl.sv */
// Overcurrent fault-response controller with host register link on its own clock
`timescale 1ns/100ps
module ocfr_ctrl (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        link_clk,
  input  wire logic        link_rst_n,
  input  wire logic        link_req,
  input  wire logic        link_write,
  input  wire logic [7:0]  link_cmd,
  input  wire logic [15:0] link_wdata,
  output logic             link_busy,
  output logic      [15:0] link_rdata,
  output logic             link_rvalid,
  input  wire logic        output_on_pin,
  input  wire logic        oc_detect_pin,
  input  wire logic        below_floor_pin,
  input  wire logic        fault_clear_pin,
  input  wire logic [15:0] time_unit_cycles,
  output logic             output_enable,
  output logic             current_limit_active,
  output logic             oc_fault_flag,
  output logic      [15:0] overcurrent_limit_value
);
  import ocfr_pkg::*;

  function automatic logic [7:0] delay_units(input logic [2:0] code);
    delay_units = 8'h01 << code;
  endfunction : delay_units

  function automatic logic retry_allowed(input logic [2:0] retry, input logic [2:0] done);
    retry_allowed = (retry == RETRY_FOREVER) || ((retry != RETRY_NONE) && (done < retry));
  endfunction : retry_allowed

  // ---------------- Link domain ----------------
  logic        lk_toggle;
  logic        lk_write_h;
  logic [7:0]  lk_cmd_h;
  logic [15:0] lk_wdata_h;
  logic        ack_q;
  logic        next_lk_toggle;
  logic        next_lk_write_h;
  logic [7:0]  next_lk_cmd_h;
  logic [15:0] next_lk_wdata_h;
  logic        next_link_busy;
  logic [15:0] next_link_rdata;
  logic        next_link_rvalid;

  // Mclk-side registers read across the crossing
  logic        m_ack;
  logic [15:0] m_rdata;

  ocfr_sync #(.W(1)) u_ack_sync (
    .clk   (link_clk),
    .ce    (1'b1),
    .rst_n (link_rst_n),
    .d     (m_ack),
    .q     (ack_q)
  );

  always_comb begin
    next_lk_toggle   = lk_toggle;
    next_lk_write_h  = lk_write_h;
    next_lk_cmd_h    = lk_cmd_h;
    next_lk_wdata_h  = lk_wdata_h;
    next_link_busy   = link_busy;
    next_link_rdata  = link_rdata;
    next_link_rvalid = 1'b0;
    if (!link_busy) begin
      // Held words stay frozen until the ack returns
      if (link_req) begin
        next_lk_toggle  = ~lk_toggle;
        next_lk_write_h = link_write;
        next_lk_cmd_h   = link_cmd;
        next_lk_wdata_h = link_wdata;
        next_link_busy  = 1'b1;
      end
    end else if (ack_q == lk_toggle) begin
      next_link_busy = 1'b0;
      if (!lk_write_h) begin
        next_link_rdata  = m_rdata;
        next_link_rvalid = 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      lk_toggle   <= 1'b0;
      lk_write_h  <= 1'b0;
      lk_cmd_h    <= 8'h00;
      lk_wdata_h  <= 16'h0000;
      link_busy   <= 1'b0;
      link_rdata  <= 16'h0000;
      link_rvalid <= 1'b0;
    end else begin
      lk_toggle   <= next_lk_toggle;
      lk_write_h  <= next_lk_write_h;
      lk_cmd_h    <= next_lk_cmd_h;
      lk_wdata_h  <= next_lk_wdata_h;
      link_busy   <= next_link_busy;
      link_rdata  <= next_link_rdata;
      link_rvalid <= next_link_rvalid;
    end
  end

  // ---------------- Mclk domain ----------------
  logic        req_q;
  logic        on_q;
  logic        oc_q;
  logic        below_q;
  logic        clr_q;

  ocfr_sync #(.W(1)) u_req_sync (
    .clk   (mclk),
    .ce    (ce),
    .rst_n (rst_n),
    .d     (lk_toggle),
    .q     (req_q)
  );

  ocfr_sync #(.W(4)) u_pin_sync (
    .clk   (mclk),
    .ce    (ce),
    .rst_n (rst_n),
    .d     ({output_on_pin, oc_detect_pin, below_floor_pin, fault_clear_pin}),
    .q     ({on_q, oc_q, below_q, clr_q})
  );

  logic [7:0]  oc_reaction;
  ocfr_state_t state;
  logic [2:0]  attempts;
  logic [15:0] unit_cnt;
  logic [7:0]  units_left;
  ocfr_state_t next_state;
  logic [2:0]  next_attempts;
  logic [15:0] next_unit_cnt;
  logic [7:0]  next_units_left;
  logic [15:0] next_limit;
  logic [7:0]  next_reaction;
  logic        next_m_ack;
  logic [15:0] next_m_rdata;
  logic        next_flag;
  logic        load_timer;
  logic        shut_down;
  logic        wr_limit;
  logic        wr_reaction;

  logic [1:0]  cfg_mode;
  logic [2:0]  cfg_retry;
  logic [2:0]  cfg_delay;
  logic [15:0] unit_len;
  logic        timer_done;

  assign cfg_mode   = oc_reaction[MODE_MSB:MODE_LSB];
  assign cfg_retry  = oc_reaction[RETRY_MSB:RETRY_LSB];
  assign cfg_delay  = oc_reaction[DELAY_MSB:DELAY_LSB];
  assign unit_len   = (time_unit_cycles == 16'h0000) ? MIN_UNIT_CYCLES : time_unit_cycles;
  assign timer_done = (units_left == 8'h00);
  assign wr_limit    = (req_q != m_ack) && lk_write_h && (lk_cmd_h == CMD_OC_LIMIT);
  assign wr_reaction = (req_q != m_ack) && lk_write_h && (lk_cmd_h == CMD_OC_REACTION);

  // Register access from the link
  always_comb begin
    next_limit    = overcurrent_limit_value;
    next_reaction = oc_reaction;
    next_m_ack    = m_ack;
    next_m_rdata  = m_rdata;
    if (wr_limit) begin
      next_limit = lk_wdata_h;
    end
    if (wr_reaction) begin
      next_reaction = lk_wdata_h[7:0];
    end
    if (req_q != m_ack) begin
      next_m_ack = req_q;
      unique case (lk_cmd_h)
        CMD_OC_LIMIT:    next_m_rdata = overcurrent_limit_value;
        CMD_OC_REACTION: next_m_rdata = {8'h00, oc_reaction};
        CMD_OC_STATUS:   next_m_rdata = {8'h00, oc_fault_flag, output_enable, current_limit_active,
                                         2'h0, attempts};
        default:         next_m_rdata = 16'h0000;
      endcase
    end
  end

  // Fault flag: a new overcurrent beats a clear in the same cycle
  assign next_flag = (oc_q && output_enable) || (oc_fault_flag && !clr_q);

  // Response state machine
  always_comb begin
    next_state      = state;
    next_attempts   = attempts;
    load_timer      = 1'b0;
    shut_down       = 1'b0;
    unique case (state)
      ST_OFF: begin
        next_attempts = 3'h0;
        if (on_q && !clr_q) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (oc_q) begin
          unique case (cfg_mode)
            MODE_CC, MODE_CC_FLOOR: next_state = ST_LIMIT;
            MODE_CC_DELAY: begin
              next_state = ST_LIMIT;
              load_timer = 1'b1;
            end
            MODE_SHUTDOWN: shut_down = 1'b1;
          endcase
        end
      end
      ST_LIMIT: begin
        if (!oc_q) begin
          next_state = ST_RUN;
        end else if (cfg_mode == MODE_CC_FLOOR && below_q) begin
          shut_down = 1'b1;
        end else if (cfg_mode == MODE_CC_DELAY && timer_done) begin
          shut_down = 1'b1;
        end else if (cfg_mode == MODE_SHUTDOWN) begin
          shut_down = 1'b1;
        end
      end
      ST_WAIT: begin
        if (timer_done) begin
          next_state = ST_RUN;
        end
      end
      ST_LATCHED: begin
        // Stays off until clear or off command below
      end
    endcase
    if (shut_down) begin
      if (retry_allowed(cfg_retry, attempts)) begin
        next_state = ST_WAIT;
        load_timer = 1'b1;
        if (cfg_retry != RETRY_FOREVER) begin
          next_attempts = attempts + 3'h1;
        end
      end else begin
        next_state = ST_LATCHED;
      end
    end
    // Off command or clear overrides everything and drops the retry history
    if (!on_q || clr_q) begin
      next_state    = ST_OFF;
      next_attempts = 3'h0;
      // A timer load here would leave a stale delay behind the clear
      load_timer    = 1'b0;
    end
  end

  // Delay timer: units counted in whole time units
  always_comb begin
    next_unit_cnt   = unit_cnt;
    next_units_left = units_left;
    if (load_timer) begin
      next_unit_cnt   = unit_len;
      next_units_left = delay_units(cfg_delay);
    end else if (next_state == ST_OFF) begin
      next_units_left = 8'h00;
    end else if (!timer_done) begin
      if (unit_cnt > MIN_UNIT_CYCLES) begin
        next_unit_cnt = unit_cnt - 16'h0001;
      end else begin
        next_unit_cnt   = unit_len;
        next_units_left = units_left - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state                   <= ST_OFF;
      attempts                <= 3'h0;
      unit_cnt                <= MIN_UNIT_CYCLES;
      units_left              <= 8'h00;
      overcurrent_limit_value <= RST_OC_LIMIT;
      oc_reaction             <= RST_OC_REACTION;
      m_ack                   <= 1'b0;
      m_rdata                 <= 16'h0000;
      oc_fault_flag           <= 1'b0;
      output_enable           <= 1'b0;
      current_limit_active    <= 1'b0;
    end else if (ce) begin
      state                   <= next_state;
      attempts                <= next_attempts;
      unit_cnt                <= next_unit_cnt;
      units_left              <= next_units_left;
      overcurrent_limit_value <= next_limit;
      oc_reaction             <= next_reaction;
      m_ack                   <= next_m_ack;
      m_rdata                 <= next_m_rdata;
      oc_fault_flag           <= next_flag;
      output_enable           <= (next_state == ST_RUN) || (next_state == ST_LIMIT);
      current_limit_active    <= (next_state == ST_LIMIT);
    end
  end

  // ---------------- Checks ----------------
  property p_forever_retry;
    @(posedge mclk) disable iff (!rst_n)
    (ce && state != ST_LATCHED && cfg_retry == RETRY_FOREVER) |=> state != ST_LATCHED;
  endproperty
  a_forever_retry: assert property (p_forever_retry) else $error("latched off with unlimited retry");

  property p_delay_units;
    @(posedge mclk) disable iff (!rst_n)
    (ce && load_timer) |=> units_left == delay_units($past(cfg_delay));
  endproperty
  a_delay_units: assert property (p_delay_units) else $error("delay unit count wrong");

  property p_unit_len;
    @(posedge mclk) disable iff (!rst_n)
    (ce && load_timer && time_unit_cycles != 16'h0000) |=> unit_cnt == $past(time_unit_cycles);
  endproperty
  a_unit_len: assert property (p_unit_len) else $error("time unit not taken from input");

  property p_wait_ends;
    @(posedge mclk) disable iff (!rst_n)
    (ce && state == ST_WAIT && timer_done && on_q && !clr_q) |=> (state == ST_RUN) && output_enable;
  endproperty
  a_wait_ends: assert property (p_wait_ends) else $error("restart not made after delay");

  property p_limit_write;
    @(posedge mclk) disable iff (!rst_n)
    (ce && wr_limit) |=> overcurrent_limit_value == $past(lk_wdata_h);
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit write lost");

  property p_reaction_write;
    @(posedge mclk) disable iff (!rst_n)
    (ce && wr_reaction) |=> oc_reaction == $past(lk_wdata_h[7:0]);
  endproperty
  a_reaction_write: assert property (p_reaction_write) else $error("reaction write lost");

  property p_flag_set;
    @(posedge mclk) disable iff (!rst_n)
    (ce && oc_q && output_enable) |=> oc_fault_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("fault flag not set");

  property p_cc_holds;
    @(posedge mclk) disable iff (!rst_n)
    (ce && state == ST_LIMIT && cfg_mode == MODE_CC && oc_q && on_q && !clr_q) |=> current_limit_active;
  endproperty
  a_cc_holds: assert property (p_cc_holds) else $error("constant-current limit left");

  property p_floor_trip;
    @(posedge mclk) disable iff (!rst_n)
    (ce && state == ST_LIMIT && cfg_mode == MODE_CC_FLOOR && oc_q && below_q) |=> !output_enable;
  endproperty
  a_floor_trip: assert property (p_floor_trip) else $error("no shutdown below floor");

  property p_hard_trip;
    @(posedge mclk) disable iff (!rst_n)
    (ce && state == ST_RUN && cfg_mode == MODE_SHUTDOWN && oc_q) |=> !output_enable;
  endproperty
  a_hard_trip: assert property (p_hard_trip) else $error("no immediate shutdown");

  property p_no_retry;
    @(posedge mclk) disable iff (!rst_n)
    (ce && shut_down && cfg_retry == RETRY_NONE && on_q && !clr_q) |=> state == ST_LATCHED;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("restart with retry zero");

  property p_clear_resets;
    @(posedge mclk) disable iff (!rst_n)
    (ce && (clr_q || !on_q)) |=> (attempts == 3'h0) && (units_left == 8'h00);
  endproperty
  a_clear_resets: assert property (p_clear_resets) else $error("attempts not reset");

endmodule : ocfr_ctrl

/* File: ocfr_pkg.sv */
// Constants, field layout and state type for the overcurrent fault-response block
package ocfr_pkg;

  // Command codes of the host-visible registers
  localparam logic [7:0]  CMD_OC_LIMIT    = 8'h46;
  localparam logic [7:0]  CMD_OC_REACTION = 8'h47;
  localparam logic [7:0]  CMD_OC_STATUS   = 8'hE0;
  // Time-unit register lives outside this block; its value arrives as a port
  localparam logic [7:0]  CMD_TIME_UNIT   = 8'hD2;

  // Values after reset
  localparam logic [15:0] RST_OC_LIMIT    = 16'h0000;
  localparam logic [7:0]  RST_OC_REACTION = 8'h00;

  // Field positions of the reaction setting
  localparam int          MODE_MSB        = 7;
  localparam int          MODE_LSB        = 6;
  localparam int          RETRY_MSB       = 5;
  localparam int          RETRY_LSB       = 3;
  localparam int          DELAY_MSB       = 2;
  localparam int          DELAY_LSB       = 0;

  // Response modes
  localparam logic [1:0]  MODE_CC         = 2'h0;
  localparam logic [1:0]  MODE_CC_FLOOR   = 2'h1;
  localparam logic [1:0]  MODE_CC_DELAY   = 2'h2;
  localparam logic [1:0]  MODE_SHUTDOWN   = 2'h3;

  // Retry codes
  localparam logic [2:0]  RETRY_NONE      = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER   = 3'h7;

  // Smallest time unit, in mclk cycles, when the unit input reads zero
  localparam logic [15:0] MIN_UNIT_CYCLES = 16'h0001;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_LIMIT,
    ST_WAIT,
    ST_LATCHED
  } ocfr_state_t;

endpackage : ocfr_pkg

/* File: ocfr_sync.sv */
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
module ocfr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         ce,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import ocfr_pkg::*;

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_s1;
  logic [W-1:0] next_s2;
  logic [W-1:0] next_s3;
  logic [W-1:0] next_q;

  always_comb begin
    next_s1 = s1;
    next_s2 = s2;
    next_s3 = s3;
    next_q  = q;
    if (ce) begin
      next_s1 = d;
      next_s2 = s1;
      next_s3 = s2;
      // Filters a single-stage glitch caught at the metastable edge
      if (s2 == s3) begin
        next_q = s3;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      q  <= next_q;
    end
  end

endmodule : ocfr_sync

/* File: ocfr_host.sv */
// Register-link host model for the overcurrent fault-response block
`timescale 1ns/100ps
module ocfr_host (
  input  wire logic        link_clk,
  input  wire logic        link_busy,
  output logic             link_req,
  output logic             link_write,
  output logic      [7:0]  link_cmd,
  output logic      [15:0] link_wdata
);
  initial begin
    link_req   = 1'b0;
    link_write = 1'b0;
    link_cmd   = 8'h00;
    link_wdata = 16'h0000;
  end

  // Busy is low between transfers, so the first edge after raising takes it
  task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] wd, input int gap);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge link_clk);
    #2;
    link_req   = 1'b1;
    link_write = wr;
    link_cmd   = cmd;
    link_wdata = wd;
    @(posedge link_clk);
    #2;
    link_req   = 1'b0;
    // Released command and data lines show the inverse so a stale value cannot pass
    link_cmd   = ~cmd;
    link_wdata = ~wd;
    while (link_busy === 1'b1 && n < 16) begin
      @(posedge link_clk);
      #2;
      n++;
    end
  endtask : xfer
endmodule : ocfr_host

/* File: testbench.sv */
// Self-checking bench for the overcurrent fault-response controller
`timescale 1ns/100ps
module testbench;
  import ocfr_pkg::*;
  logic        mclk, rst_n, ce, link_clk, link_rst_n;
  logic        link_req, link_write, link_busy, link_rvalid;
  logic [7:0]  link_cmd;
  logic [15:0] link_wdata, link_rdata, time_unit_cycles, overcurrent_limit_value;
  logic        output_on_pin, oc_detect_pin, below_floor_pin, fault_clear_pin;
  logic        output_enable, current_limit_active, oc_fault_flag;
  logic [15:0] exp_q[$];
  logic [15:0] v, w;
  int          bad_count, compares, rises, lim_cyc, off_run, off_max, t;

  ocfr_ctrl ocfr_ctrl_i (.mclk(mclk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk), .link_rst_n(link_rst_n),
    .link_req(link_req), .link_write(link_write), .link_cmd(link_cmd), .link_wdata(link_wdata),
    .link_busy(link_busy), .link_rdata(link_rdata), .link_rvalid(link_rvalid), .output_on_pin(output_on_pin),
    .oc_detect_pin(oc_detect_pin), .below_floor_pin(below_floor_pin), .fault_clear_pin(fault_clear_pin),
    .time_unit_cycles(time_unit_cycles), .output_enable(output_enable),
    .current_limit_active(current_limit_active), .oc_fault_flag(oc_fault_flag),
    .overcurrent_limit_value(overcurrent_limit_value));
  ocfr_host ocfr_host_i (.link_clk(link_clk), .link_busy(link_busy), .link_req(link_req),
    .link_write(link_write), .link_cmd(link_cmd), .link_wdata(link_wdata));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : check_rng

  // Read answers are matched oldest first
  always @(posedge link_clk) begin
    #1;
    if (link_rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(16'(exp_q.size()), 16'h0001);
      else check(link_rdata, exp_q.pop_front());
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc

  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    ocfr_host_i.xfer(1'b1, cmd, d, $urandom % 3);
    check({15'h0000, link_busy}, 16'h0000);
  endtask : wr

  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    exp_q.push_back(exp);
    ocfr_host_i.xfer(1'b0, cmd, 16'h0000, $urandom % 3);
    check({15'h0000, link_busy}, 16'h0000);
  endtask : rd

  task automatic pins(input logic on, input logic oc, input logic below, input logic clr);
    output_on_pin   = on;
    oc_detect_pin   = oc;
    below_floor_pin = below;
    fault_clear_pin = clr;
  endtask : pins

  task automatic restart;
    pins(1'b1, 1'b0, 1'b0, 1'b1);
    cyc(8);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(8);
  endtask : restart

  task automatic watch(input int n);
    logic last;
    rises   = 0;
    lim_cyc = 0;
    off_run = 0;
    off_max = 0;
    last    = output_enable;
    repeat (n) begin
      cyc(1);
      if (output_enable === 1'b1 && last !== 1'b1) rises++;
      if (current_limit_active === 1'b1) lim_cyc++;
      off_run = (output_enable === 1'b1) ? 0 : off_run + 1;
      if (off_run > off_max) off_max = off_run;
      last = output_enable;
    end
  endtask : watch

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial begin
    #2000000;
    bad_count++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    link_rst_n = 1'b0;
    ce = 1'b1;
    time_unit_cycles = 16'h0002;
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    bad_count = 0;
    compares = 0;
    void'($urandom(17));
    cyc(6);
    rst_n = 1'b1;
    link_rst_n = 1'b1;
    rd(CMD_OC_LIMIT, RST_OC_LIMIT);
    rd(CMD_OC_REACTION, {8'h00, RST_OC_REACTION});
    v = 16'($urandom);
    w = 16'($urandom);
    wr(CMD_OC_LIMIT, v);
    rd(CMD_OC_LIMIT, v);
    check(overcurrent_limit_value, v);
    wr(CMD_OC_REACTION, w);
    rd(CMD_OC_REACTION, {8'h00, w[7:0]});
    wr(8'h00, 16'h5A5A);
    rd(8'h00, 16'h0000);
    rd(CMD_TIME_UNIT, 16'h0000);
    rd(CMD_OC_LIMIT, v);
    // Constant-current limiting never drops the output
    wr(CMD_OC_REACTION, {8'h00, MODE_CC, RETRY_NONE, 3'h0});
    restart();
    check({15'h0000, output_enable}, 16'h0001);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    watch(200);
    check_rng(lim_cyc, 194, 200);
    check_rng(off_max, 0, 0);
    check({15'h0000, oc_fault_flag}, 16'h0001);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(8);
    rd(CMD_OC_STATUS, 16'h00C0);
    // Floor mode: limit above floor, shut down and stay off below it
    wr(CMD_OC_REACTION, {8'h00, MODE_CC_FLOOR, RETRY_NONE, 3'h0});
    restart();
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    watch(100);
    check_rng(lim_cyc, 94, 100);
    check_rng(off_max, 0, 0);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    watch(100);
    check_rng(off_max, 94, 100);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    watch(50);
    check_rng(rises, 0, 0);
    restart();
    check({15'h0000, output_enable}, 16'h0001);
    // Delayed limiting; unit length varies per code
    for (int d = 0; d < 4; d++) begin
      time_unit_cycles = 16'(d + 3);
      t = (1 << d) * (d + 3);
      wr(CMD_OC_REACTION, {8'h00, MODE_CC_DELAY, RETRY_NONE, 3'(d)});
      restart();
      pins(1'b1, 1'b1, 1'b0, 1'b0);
      watch(150);
      check_rng(lim_cyc, t - 1, t + 2);
      check({15'h0000, output_enable}, 16'h0000);
    end
    // Shutdown with two retries, then again after off and on
    time_unit_cycles = 16'h0004;
    wr(CMD_OC_REACTION, {8'h00, MODE_SHUTDOWN, 3'h2, 3'h1});
    restart();
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    watch(300);
    check_rng(rises, 2, 2);
    rd(CMD_OC_STATUS, 16'h0082);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    cyc(8);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    watch(300);
    check_rng(rises, 3, 3);
    // Endless retries spaced by four time units of four cycles, sixteen mclk cycles
    wr(CMD_OC_REACTION, {8'h00, MODE_SHUTDOWN, RETRY_FOREVER, 3'h2});
    restart();
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    watch(400);
    check_rng(rises, 12, 400);
    check_rng(off_max, 16, 19);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(40);
    check({15'h0000, output_enable}, 16'h0001);
    // Clock enable low freezes the response, synchronisers included
    ce = 1'b0;
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    cyc(12);
    check({15'h0000, output_enable}, 16'h0001);
    ce = 1'b1;
    cyc(8);
    check({15'h0000, output_enable}, 16'h0000);
    repeat (4) @(posedge link_clk);
    check(16'(exp_q.size()), 16'h0000);
    give_verdict();
  end
endmodule : testbench
